// [hw/ctrl_port_pkg.sv]
// Purpose: shared constants for the control port front end
// Assumes: byte-wide host port, 3-bit external address, 20-bit internal words
// Notes:   two register groups, one per chip select / serial port
package ctrl_port_pkg;
  // external 3-bit register map
  localparam logic [2:0] EXT_DATA_LOW    = 3'h0; // data_low_byte, triggers internal access
  localparam logic [2:0] EXT_DATA_MID    = 3'h1; // data_mid_byte
  localparam logic [2:0] EXT_DATA_TOP    = 3'h2; // data_top_nibble
  localparam logic [2:0] EXT_SLEEP       = 3'h3;
  localparam logic [2:0] EXT_PIN_SYNC    = 3'h4;
  localparam logic [2:0] EXT_SOFT_SYNC   = 3'h5;
  localparam logic [2:0] EXT_CHAN_ADDR   = 3'h6; // channel_address_low
  localparam logic [2:0] EXT_ADDR_CTRL   = 3'h7; // address_control
  localparam int         EXT_REGS        = 8;
  localparam int         GROUPS          = 2;
  localparam logic [7:0] TOP_NIBBLE_MASK = 8'h0F;
  localparam logic [7:0] EXT_RESET       = 8'h00;
  // internal word layout
  localparam int         INT_ADDR_W      = 10;
  localparam int         INT_DATA_W      = 20;
  localparam int         MID_LSB         = 8;
  localparam int         TOP_LSB         = 16;
  localparam int         TOP_W           = 4;
  localparam int         ADDR_HI_W       = 2;
  // serial frame layout
  localparam int         SER_IGNORE      = 4;  // don't-care bits after the frame bit
  localparam int         SER_BITS        = 11; // 3 address + 8 data
  localparam int         SER_ADDR_LSB    = 8;
  localparam int         SER_CNT_W       = 4;
  localparam logic [SER_CNT_W-1:0] SER_LAST = 4'hF; // SER_IGNORE + SER_BITS
  localparam logic [SER_CNT_W-1:0] SER_FIRST_DATA = 4'h5; // SER_IGNORE + 1
  // parallel style select levels
  localparam logic SPLIT_STROBE_STYLE     = 1'b0;
  localparam logic DIRECTION_LINE_STYLE   = 1'b1;
  // synchroniser stages
  localparam int         SYNC_STAGES     = 2;
endpackage : ctrl_port_pkg

// [hw/serial_word_if.sv]
// Purpose: carries one received serial control word into the core domain
// Assumes: word stays stable while pulse is high
// Notes:   src side is the serial receiver, dst side the arbiter
`timescale 1ns/100ps
`default_nettype none
interface serial_word_if;
  logic                            pulse; // one core cycle per completed frame
  logic [ctrl_port_pkg::SER_BITS-1:0] word;  // {addr[2:0], data[7:0]}
  modport src (output pulse, output word);
  modport dst (input pulse, input word);
endinterface : serial_word_if
`default_nettype wire

// [hw/serial_frame_rx.sv]
// Purpose: self-framing write-only serial control receiver
// Assumes: serial clock supplied by the controller, may stop between frames
// Notes:   word crosses to the core clock by a toggle and two flops
`timescale 1ns/100ps
`default_nettype none
module serial_frame_rx (
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  serial_word_if.src       out_if
);
  logic                                busy_reg;
  logic [ctrl_port_pkg::SER_CNT_W-1:0] cnt_reg;
  logic [ctrl_port_pkg::SER_CNT_W-1:0] cnt_next;
  logic [ctrl_port_pkg::SER_BITS-1:0]  shift_reg;
  logic [ctrl_port_pkg::SER_BITS-1:0]  word_reg;
  logic                                tog_reg;
  logic                                tog_meta_reg;
  logic                                tog_sync_reg;
  logic                                tog_seen_reg;
  logic [ctrl_port_pkg::SER_BITS-1:0]  word_core_reg;
  logic                                pulse_reg;

  assign cnt_next = cnt_reg + 4'h1;

  // frame detect, skip don't-care bits, then shift 11 bits on falling edges
  always_ff @(negedge ser_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_reg  <= 1'b0;
      cnt_reg   <= '0;
      shift_reg <= '0;
      word_reg  <= '0;
      tog_reg   <= 1'b0;
    end else if (!busy_reg) begin
      if (ser_data_in) begin
        busy_reg <= 1'b1;
        cnt_reg  <= '0;
      end
    end else begin
      cnt_reg <= cnt_next;
      if (cnt_next >= ctrl_port_pkg::SER_FIRST_DATA) begin
        shift_reg <= {shift_reg[ctrl_port_pkg::SER_BITS-2:0], ser_data_in};
      end
      if (cnt_next == ctrl_port_pkg::SER_LAST) begin
        busy_reg <= 1'b0;
        word_reg <= {shift_reg[ctrl_port_pkg::SER_BITS-2:0], ser_data_in};
        tog_reg  <= ~tog_reg; // word_reg settles long before the toggle is seen
      end
    end
  end

  // toggle synchroniser, one pulse per frame in the core domain
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_meta_reg  <= 1'b0;
      tog_sync_reg  <= 1'b0;
      tog_seen_reg  <= 1'b0;
      pulse_reg     <= 1'b0;
      word_core_reg <= '0;
    end else if (clk_en_in) begin
      tog_meta_reg <= tog_reg;
      tog_sync_reg <= tog_meta_reg;
      tog_seen_reg <= tog_sync_reg;
      pulse_reg    <= tog_sync_reg ^ tog_seen_reg;
      if (tog_sync_reg ^ tog_seen_reg) begin
        word_core_reg <= word_reg;
      end
    end
  end

  assign out_if.pulse = pulse_reg;
  assign out_if.word  = word_core_reg;
endmodule // serial_frame_rx
`default_nettype wire

// [hw/control_port_front_end.sv]
// Purpose: host control front end: byte parallel port, two serial ports, word staging
// Assumes: internal register file answers int_done_in on ref_clk_in
// Notes:   pins pass two flops; serial domains are not frozen by clk_en_in
//
// How it works
// - Split-strobe style: ready output low from access start until internal access ends.
// - Direction style: acknowledge low on completion, high after strobe release.
// - Lower serial port reaches the group of select line a, ahead of parallel.
// - Upper serial port reaches the group of select line b, ahead of parallel.
// - Each serial port writes exactly the registers of its matching select line.
// - Frame bit high on falling edge, skip four bits, then shift eleven.
// - Eleven bits give 3-bit address and 8-bit data for one register write.
// - Serial data sampled on falling edges; controller keeps it stable there.
// - Write upper bytes first; low byte write copies the whole word inside.
// - Low byte read returns bits 7..0 and loads upper bytes for later.
// - Top data register keeps four bits; upper bits dropped, read as zero.
// - Several accesses per chip select, each with a fresh strobe pulse.
`timescale 1ns/100ps
`default_nettype none
module control_port_front_end #(
  parameter int ADDR_W = ctrl_port_pkg::INT_ADDR_W,
  parameter int WORD_W = ctrl_port_pkg::INT_DATA_W
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              clk_en_in,
  input  wire logic              style_sel_in,        // low split strobes, high direction line
  input  wire logic              select_line_a_n_in,
  input  wire logic              select_line_b_n_in,
  input  wire logic              read_strobe_n_in,    // data_strobe in direction style
  input  wire logic              write_strobe_n_in,   // direction line in direction style
  input  wire logic [2:0]        addr_in,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_out,
  output logic                   access_ready_out,
  output logic                   transfer_ack_n_out,
  input  wire logic              serial_clock_lower_in,
  input  wire logic              serial_in_lower_in,
  input  wire logic              serial_clock_upper_in,
  input  wire logic              serial_in_upper_in,
  output logic                   int_write_out,
  output logic                   int_read_out,
  output logic                   int_group_out,
  output logic      [ADDR_W-1:0] int_addr_out,
  output logic      [WORD_W-1:0] int_wdata_out,
  input  wire logic [WORD_W-1:0] int_rdata_in,
  input  wire logic              int_done_in,
  output logic      [47:0]       group_ctrl_out
);
  typedef enum logic [1:0] {P_IDLE, P_PEND, P_DONE} par_state_t;
  typedef enum logic {E_IDLE, E_INT} eng_state_t;

  serial_word_if ser_if [ctrl_port_pkg::GROUPS] ();

  logic [15:0]   pin_meta_reg;
  logic [15:0]   pin_sync_reg;
  logic          style;
  logic          sel_a;
  logic          sel_b;
  logic          rd_n;
  logic          wr_n;
  logic [2:0]    p_addr;
  logic [7:0]    p_data;
  logic          strobe_act;
  logic          strobe_is_rd;
  par_state_t    par_state_reg;
  eng_state_t    eng_state_reg;
  logic          par_grp_reg;
  logic          par_rd_reg;
  logic [2:0]    par_addr_reg;
  logic [7:0]    par_wdata_reg;
  logic [1:0]    ser_pend_reg;
  logic [1:0]    ser_pulse;
  logic [10:0]   ser_word [ctrl_port_pkg::GROUPS];
  logic [7:0]    ext_reg [ctrl_port_pkg::GROUPS][ctrl_port_pkg::EXT_REGS];
  logic          eng_src_ser_reg;
  logic          eng_rd_reg;
  logic          eng_grp_reg;
  logic          ser_go;
  logic          par_go;
  logic          acc_go;
  logic          acc_grp;
  logic          acc_rd;
  logic [2:0]    acc_addr;
  logic [7:0]    acc_data;
  logic          acc_internal;
  logic          int_finish;
  logic [7:0]    rd_value;

  // one receiver per serial port
  serial_frame_rx u_rx_lower (
    .ser_clk_in  (serial_clock_lower_in),
    .ser_data_in (serial_in_lower_in),
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .out_if      (ser_if[0])
  );
  serial_frame_rx u_rx_upper (
    .ser_clk_in  (serial_clock_upper_in),
    .ser_data_in (serial_in_upper_in),
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .out_if      (ser_if[1])
  );
  assign ser_pulse   = {ser_if[1].pulse, ser_if[0].pulse};
  assign ser_word[0] = ser_if[0].word;
  assign ser_word[1] = ser_if[1].word;

  // host pins are asynchronous to the core clock
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_reg <= 16'h00FF;
      pin_sync_reg <= 16'h00FF;
    end else if (clk_en_in) begin
      pin_meta_reg <= {data_in, addr_in, write_strobe_n_in, read_strobe_n_in,
                       select_line_b_n_in, select_line_a_n_in, style_sel_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign style  = pin_sync_reg[0];
  assign sel_a  = !pin_sync_reg[1];
  assign sel_b  = !pin_sync_reg[2];
  assign rd_n   = pin_sync_reg[3];
  assign wr_n   = pin_sync_reg[4];
  assign p_addr = pin_sync_reg[7:5];
  assign p_data = pin_sync_reg[15:8];

  // decode the two strobe styles
  always_comb begin
    if (style == ctrl_port_pkg::DIRECTION_LINE_STYLE) begin
      strobe_act   = (sel_a || sel_b) && !rd_n;
      strobe_is_rd = wr_n;
    end else begin
      strobe_act   = (sel_a || sel_b) && (!rd_n || !wr_n);
      strobe_is_rd = !rd_n;
    end
  end

  // arbitration: serial before parallel, lower group first
  assign ser_go  = (ser_pend_reg != 2'b00) && (eng_state_reg == E_IDLE);
  assign par_go  = !ser_go && (par_state_reg == P_PEND) && (eng_state_reg == E_IDLE);
  assign acc_go  = ser_go || par_go;
  assign acc_grp = ser_go ? !ser_pend_reg[0] : par_grp_reg;
  assign acc_rd  = ser_go ? 1'b0 : par_rd_reg;
  assign acc_addr = ser_go ? ser_word[acc_grp][10:ctrl_port_pkg::SER_ADDR_LSB]
                           : par_addr_reg;
  assign acc_data = ser_go ? ser_word[acc_grp][7:0] : par_wdata_reg;
  assign acc_internal = (acc_addr == ctrl_port_pkg::EXT_DATA_LOW);
  assign int_finish   = (eng_state_reg == E_INT) && int_done_in;

  // register read mux; write-only controls read as zero
  always_comb begin
    rd_value = 8'h00;
    unique case (acc_addr)
      ctrl_port_pkg::EXT_DATA_MID,
      ctrl_port_pkg::EXT_CHAN_ADDR,
      ctrl_port_pkg::EXT_ADDR_CTRL: rd_value = ext_reg[acc_grp][acc_addr];
      ctrl_port_pkg::EXT_DATA_TOP:  rd_value = ext_reg[acc_grp][acc_addr]
                                               & ctrl_port_pkg::TOP_NIBBLE_MASK;
      default:                      rd_value = 8'h00;
    endcase
  end

  // pending serial words; a new frame beats the clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ser_pend_reg <= 2'b00;
    end else if (clk_en_in) begin
      ser_pend_reg <= (ser_pend_reg & ~(ser_go ? (acc_grp ? 2'b10 : 2'b01) : 2'b00))
                      | ser_pulse;
    end
  end

  // parallel access sequence
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_state_reg <= P_IDLE;
      par_grp_reg   <= 1'b0;
      par_rd_reg    <= 1'b0;
      par_addr_reg  <= 3'h0;
      par_wdata_reg <= 8'h00;
    end else if (clk_en_in) begin
      unique case (par_state_reg)
        P_IDLE: if (strobe_act) begin
          par_state_reg <= P_PEND;
          par_grp_reg   <= !sel_a;
          par_rd_reg    <= strobe_is_rd;
          par_addr_reg  <= p_addr;
          par_wdata_reg <= p_data;
        end
        P_PEND: if ((par_go && !acc_internal) || (int_finish && !eng_src_ser_reg)) begin
          par_state_reg <= P_DONE;
        end
        P_DONE: if (!strobe_act) begin // fresh strobe needed per access
          par_state_reg <= P_IDLE;
        end
      endcase
    end
  end

  // register writes, internal transfers and read data
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eng_state_reg   <= E_IDLE;
      eng_src_ser_reg <= 1'b0;
      eng_rd_reg      <= 1'b0;
      eng_grp_reg     <= 1'b0;
      int_write_out   <= 1'b0;
      int_read_out    <= 1'b0;
      int_addr_out    <= '0;
      int_wdata_out   <= '0;
      data_out        <= 8'h00;
      for (int g = 0; g < ctrl_port_pkg::GROUPS; g++) begin
        for (int r = 0; r < ctrl_port_pkg::EXT_REGS; r++) begin
          ext_reg[g][r] <= ctrl_port_pkg::EXT_RESET;
        end
      end
    end else if (clk_en_in) begin
      int_write_out <= 1'b0;
      int_read_out  <= 1'b0;
      if (acc_go) begin
        eng_src_ser_reg <= ser_go;
        eng_rd_reg      <= acc_rd;
        eng_grp_reg     <= acc_grp;
        int_addr_out    <= ADDR_W'({ext_reg[acc_grp][ctrl_port_pkg::EXT_ADDR_CTRL]
                                    [ctrl_port_pkg::ADDR_HI_W-1:0],
                                    ext_reg[acc_grp][ctrl_port_pkg::EXT_CHAN_ADDR]});
        if (!acc_rd) begin
          ext_reg[acc_grp][acc_addr] <= (acc_addr == ctrl_port_pkg::EXT_DATA_TOP)
                                        ? (acc_data & ctrl_port_pkg::TOP_NIBBLE_MASK)
                                        : acc_data;
        end else begin
          data_out <= rd_value;
        end
        if (acc_internal) begin
          eng_state_reg <= E_INT;
          int_write_out <= !acc_rd;
          int_read_out  <= acc_rd;
          int_wdata_out <= WORD_W'({ext_reg[acc_grp][ctrl_port_pkg::EXT_DATA_TOP]
                                    [ctrl_port_pkg::TOP_W-1:0],
                                    ext_reg[acc_grp][ctrl_port_pkg::EXT_DATA_MID],
                                    acc_data});
        end
      end else if (int_finish) begin
        eng_state_reg <= E_IDLE;
        if (eng_rd_reg) begin
          // low byte to the host now, upper bytes parked for later reads
          data_out <= int_rdata_in[7:0];
          ext_reg[eng_grp_reg][ctrl_port_pkg::EXT_DATA_LOW] <= int_rdata_in[7:0];
          ext_reg[eng_grp_reg][ctrl_port_pkg::EXT_DATA_MID] <=
            int_rdata_in[ctrl_port_pkg::TOP_LSB-1:ctrl_port_pkg::MID_LSB];
          ext_reg[eng_grp_reg][ctrl_port_pkg::EXT_DATA_TOP] <=
            {4'h0, int_rdata_in[ctrl_port_pkg::TOP_LSB+ctrl_port_pkg::TOP_W-1:
                                ctrl_port_pkg::TOP_LSB]};
        end
      end
    end
  end

  assign int_group_out = eng_grp_reg;

  // handshake pins; in split-strobe style ready stays low while the access waits or runs
  assign access_ready_out   = !((style == ctrl_port_pkg::SPLIT_STROBE_STYLE)
                                && (par_state_reg == P_PEND));
  assign transfer_ack_n_out = !((style == ctrl_port_pkg::DIRECTION_LINE_STYLE)
                                && (par_state_reg == P_DONE));
  assign data_oe_out        = (par_state_reg == P_DONE) && par_rd_reg;

  // write-only control registers, lower group in the low half
  assign group_ctrl_out = {ext_reg[1][ctrl_port_pkg::EXT_SOFT_SYNC],
                           ext_reg[1][ctrl_port_pkg::EXT_PIN_SYNC],
                           ext_reg[1][ctrl_port_pkg::EXT_SLEEP],
                           ext_reg[0][ctrl_port_pkg::EXT_SOFT_SYNC],
                           ext_reg[0][ctrl_port_pkg::EXT_PIN_SYNC],
                           ext_reg[0][ctrl_port_pkg::EXT_SLEEP]};
endmodule // control_port_front_end
`default_nettype wire

// [tb/control_port_front_end_assertions.sv]
// Purpose: concurrent checks on the host handshake of the control port front end
// Assumes: style pin held steady around each access, select line a used for timing
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module control_port_front_end_assertions (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic style_sel_in,
  input  wire logic select_line_a_n_in,
  input  wire logic read_strobe_n_in,
  input  wire logic write_strobe_n_in,
  input  wire logic data_oe_out,
  input  wire logic access_ready_out,
  input  wire logic transfer_ack_n_out,
  input  wire logic int_write_out,
  input  wire logic int_read_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // start of an access in each style, as seen at the pins
  sequence split_start;
    !style_sel_in && !select_line_a_n_in && $fell(write_strobe_n_in);
  endsequence
  sequence dir_start;
    style_sel_in && !select_line_a_n_in && $fell(read_strobe_n_in);
  endsequence
  // pin flops delay the start, so a short window rather than a fixed cycle
  split_ready_a: assert property (split_start |-> ##[1:6] !access_ready_out)
    else $error("ready not lowered after split strobe");
  ready_style_a: assert property ($fell(access_ready_out) |-> !style_sel_in)
    else $error("ready lowered in direction style");
  ready_run_a: assert property (int_read_out && !style_sel_in |-> !access_ready_out)
    else $error("ready high while internal read runs");
  dir_ack_a: assert property (dir_start |-> ##[2:20] !transfer_ack_n_out)
    else $error("acknowledge missing after data strobe");
  ack_style_a: assert property ($fell(transfer_ack_n_out) |-> style_sel_in)
    else $error("acknowledge given in split style");
  ack_hold_a:
    assert property (!transfer_ack_n_out && !read_strobe_n_in |=> !transfer_ack_n_out)
    else $error("acknowledge released under held strobe");
  ack_release_a:
    assert property ($rose(transfer_ack_n_out) |-> $past(read_strobe_n_in, 2))
    else $error("acknowledge released before strobe");
  read_pulse_a: assert property (int_read_out |=> !int_read_out)
    else $error("internal read longer than one cycle");
  write_once_a: assert property (int_write_out |=> !int_write_out)
    else $error("internal write longer than one cycle");
  read_drive_a: assert property ($rose(data_oe_out) |-> !read_strobe_n_in)
    else $error("data driven without a read strobe");
endmodule // control_port_front_end_assertions
bind control_port_front_end control_port_front_end_assertions u_checker (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .style_sel_in(style_sel_in),
  .select_line_a_n_in(select_line_a_n_in), .read_strobe_n_in(read_strobe_n_in),
  .write_strobe_n_in(write_strobe_n_in), .data_oe_out(data_oe_out),
  .access_ready_out(access_ready_out), .transfer_ack_n_out(transfer_ack_n_out),
  .int_write_out(int_write_out), .int_read_out(int_read_out)
);
`default_nettype wire

// [tb/serial_host_model.sv]
// Purpose: controller model driving one self-framing serial control port
// Assumes: 64 ns serial clock, parked high between frames
// Notes:   frames are sent by calling send from the bench
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  output logic ser_clk_out,
  output logic ser_data_out
);
  localparam int HALF_NS = 32; // 64 ns period, far below the port limit
  // data parked low, a high idle level would be taken as a frame bit
  initial begin
    ser_clk_out = 1'b1; // the port is a slave, we make its clock
    ser_data_out = 1'b0;
  end
  // frame bit, four filler bits, address then data, msb first
  task automatic send(input logic [2:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {1'b1, 4'hA, addr, data};
    #3; // moves the first data change 3 ns past the call time
    for (int i = 15; i >= 0; i--) begin
      ser_data_out = frame[i]; // changed just after the rising edge
      #HALF_NS ser_clk_out = 1'b0; // port samples on this falling edge
      #HALF_NS ser_clk_out = 1'b1;
    end
    ser_data_out = 1'b0;
  endtask
endmodule // serial_host_model
`default_nettype wire

// [tb/control_port_front_end_tb.sv]
// Purpose: self-checking bench for the control port front end
// Assumes: internal register file answers two cycles after each request
// Notes:   random data from a fixed seed, frames from two controller models
`timescale 1ns/100ps
`default_nettype none
module control_port_front_end_tb;
  logic        clk, rst_n, clk_en, style, cs_a_n, cs_b_n, rd_n, wr_n, oe, rdy, ack_n;
  logic        iwr, ird, igrp, idone, req_d, last_wgrp;
  logic [2:0]  addr;
  logic [7:0]  wdat, rdat;
  logic [9:0]  iaddr, last_waddr;
  logic [19:0] iwdata, irdata, last_wdata;
  logic [47:0] gctl;
  wire         sck_lo, sdi_lo, sck_hi, sdi_hi;
  int          seed, errors, total_checks, wr_count;

  control_port_front_end u_control_port_front_end (
    .ref_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en), .style_sel_in(style),
    .select_line_a_n_in(cs_a_n), .select_line_b_n_in(cs_b_n), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .addr_in(addr), .data_in(wdat), .data_out(rdat),
    .data_oe_out(oe), .access_ready_out(rdy), .transfer_ack_n_out(ack_n),
    .serial_clock_lower_in(sck_lo), .serial_in_lower_in(sdi_lo),
    .serial_clock_upper_in(sck_hi), .serial_in_upper_in(sdi_hi), .int_write_out(iwr),
    .int_read_out(ird), .int_group_out(igrp), .int_addr_out(iaddr),
    .int_wdata_out(iwdata), .int_rdata_in(irdata), .int_done_in(idone),
    .group_ctrl_out(gctl)
  );
  serial_host_model u_ser_lo (.ser_clk_out(sck_lo), .ser_data_out(sdi_lo));
  serial_host_model u_ser_hi (.ser_clk_out(sck_hi), .ser_data_out(sdi_hi));

  // core clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // internal register file: done two cycles after a request, keeps the last write
  always @(posedge clk) begin
    req_d <= iwr | ird;
    idone <= req_d;
    if (iwr) begin
      last_wdata <= iwdata;
      last_waddr <= iaddr;
      last_wgrp <= igrp;
      wr_count <= wr_count + 1;
    end
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected data register byte k of an internal word; the top register keeps four bits
  function automatic logic [7:0] byte_of(input logic [19:0] w, input int k);
    return 8'(w >> (8 * k)) & ((k == 2) ? 8'h0F : 8'hFF);
  endfunction
  // bounded wait for ready or acknowledge to reach a level
  task automatic wait_lvl(input bit on_ack, input logic lvl);
    int n;
    n = 0;
    while ((on_ack ? ack_n : rdy) !== lvl && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) begin
      errors++;
      $display("CHECK FAILED at %0t: handshake timeout", $time);
    end
  endtask
  // one parallel access; the select is left low so accesses chain
  task automatic host(input logic grp, input logic wr, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    cs_a_n <= grp;
    cs_b_n <= ~grp;
    addr <= a;
    wdat <= d;
    wr_n <= ~wr; // write strobe, or direction line low for a write
    rd_n <= style ? 1'b0 : wr;
    @(posedge clk);
    wait_lvl(style, 1'b0);
    if (!style) wait_lvl(1'b0, 1'b1);
    q = rdat;
    chk(oe, !wr);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
    if (style) wait_lvl(1'b1, 1'b1);
    else repeat (4) @(posedge clk);
  endtask
  // one serial frame, then either straight on or a settling gap
  task automatic ser_frame(input int p, input logic [2:0] a, input logic [7:0] d, input bit quick);
    if (p == 0) u_ser_lo.send(a, d);
    else u_ser_hi.send(a, d);
    if (!quick) repeat (10) @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run of about 2000 cycles
  initial begin
    #200000;
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    logic [7:0]  v[8];
    logic [7:0]  q, sd;
    logic [9:0]  c;
    logic [19:0] w;
    int          n;
    seed = 66798;
    errors = 0; total_checks = 0; wr_count = 0; req_d = 1'b0; idone = 1'b0;
    clk_en = 1'b1; style = 1'b0; cs_a_n = 1'b1; cs_b_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1;
    addr = 3'h0; wdat = 8'h00; irdata = 20'h00000; rst_n = 1'b0;
    repeat (12) @(posedge clk);
    chk({rdy, ack_n, oe, iwr, ird}, 5'h18);
    chk(gctl, 48'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // chained accesses on both selects, group registers and readback
    for (int g = 0; g < 2; g++) begin
      for (int r = 3; r < 8; r++) begin
        v[r] = 8'($random(seed));
        host(g[0], 1'b1, r[2:0], v[r], q);
      end
      for (int r = 6; r < 8; r++) begin
        host(g[0], 1'b0, r[2:0], 8'h00, q);
        chk(q, v[r]);
      end
      chk(gctl[g*24 +: 24], {v[5], v[4], v[3]});
    end
    // frozen core: a full strobe in group b must leave its registers alone
    clk_en <= 1'b0;
    addr <= 3'h3;
    wdat <= ~v[3];
    wr_n <= 1'b0;
    repeat (6) @(posedge clk);
    wr_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({rdy, gctl[31:24]}, {1'b1, v[3]});
    clk_en <= 1'b1;
    $display("test 1 done");
    // staged internal write and read in each strobe style
    for (int s = 0; s < 2; s++) begin
      style <= s[0];
      repeat (4) @(posedge clk);
      c = 10'($random(seed));
      w = 20'($random(seed));
      n = wr_count;
      host(1'b0, 1'b1, 3'h7, {6'h00, c[9:8]}, q);
      host(1'b0, 1'b1, 3'h6, c[7:0], q);
      host(1'b0, 1'b1, 3'h2, {4'hF, w[19:16]}, q); // junk upper nibble
      host(1'b0, 1'b1, 3'h1, w[15:8], q);
      chk(wr_count - n, 0);
      host(1'b0, 1'b1, 3'h0, w[7:0], q);
      chk(wr_count - n, 1);
      chk({last_wgrp, last_waddr, last_wdata}, {1'b0, c, w});
      w = 20'($random(seed));
      irdata <= w;
      host(1'b0, 1'b0, 3'h0, 8'h00, q);
      chk(q, byte_of(w, 0));
      irdata <= ~w; // upper bytes must already be latched
      host(1'b0, 1'b0, 3'h1, 8'h00, q);
      chk(q, byte_of(w, 1));
      host(1'b0, 1'b0, 3'h2, 8'h00, q);
      chk(q, byte_of(w, 2));
      cs_a_n <= 1'b1;
      @(posedge clk);
    end
    $display("test 2 done");
    // serial frames build a word in the port's own group, some back to back
    for (int p = 0; p < 2; p++) begin
      c = 10'($random(seed));
      w = 20'($random(seed));
      sd = 8'($random(seed));
      n = wr_count;
      ser_frame(p, 3'h7, {6'h00, c[9:8]}, 1'b0);
      ser_frame(p, 3'h6, c[7:0], 1'b1);
      ser_frame(p, 3'h2, {4'h0, w[19:16]}, 1'b1);
      ser_frame(p, 3'h1, w[15:8], 1'b0);
      ser_frame(p, 3'h0, w[7:0], 1'b0);
      ser_frame(p, 3'h4, sd, 1'b0);
      chk(wr_count - n, 1);
      chk({last_wgrp, last_waddr, last_wdata}, {p[0], c, w});
      chk(gctl[p*24+8 +: 8], sd);
    end
    $display("test 3 done");
    // serial write racing a run of parallel writes to the same group
    sd = 8'($random(seed));
    for (int k = 0; k < 8; k++) v[k] = 8'($random(seed));
    fork
      ser_frame(0, 3'h5, sd, 1'b0);
      begin
        repeat (40) @(posedge clk); // parallel run straddles the serial word's arrival
        for (int k = 0; k < 8; k++) host(1'b0, 1'b1, 3'h3, v[k], q);
      end
    join
    chk({gctl[23:16], gctl[7:0]}, {sd, v[7]});
    $display("test 4 done");
    test_done();
  end
endmodule // control_port_front_end_tb
`default_nettype wire
